/* File: desc_attr_chk.sv */
// Checker for the descriptor attribute bank: read port timing, reserved bits, status.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/10ps
`default_nettype none
module desc_attr_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic [11:0] i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_eeprom_present,
   input wire logic        i_otp_configured,
   input wire logic        i_image_load,
   input wire logic        i_usb_reset,
   input wire logic        i_lite_reset,
   input wire logic [31:0] o_rdata,
   input wire logic        o_attributes_active,
   input wire logic [79:0] o_attributes
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // The answer cycle of a read taken at a given address.
   sequence rd_at(a);
      $past(i_rd) && $past(i_addr) == a;
   endsequence
   // Six quiet cycles leave every synchronised load or reset edge fully settled.
   sequence quiet;
      !(i_wr || i_image_load || i_usb_reset || i_lite_reset) [*6];
   endsequence
   fs_reserved_a: assert property (rd_at(12'h05C) |-> o_rdata[31:24] == 8'h00)
      else $error("full speed top byte not zero");
   str1_reserved_a: assert property (rd_at(12'h064) |-> o_rdata[31:8] == 24'h0)
      else $error("string register 1 upper bits not zero");
   flag_reserved_a: assert property (rd_at(12'h068) |-> o_rdata[31:16] == 16'h0)
      else $error("wake flag upper bits not zero");
   unmapped_zero_a: assert property (rd_at(12'h078) |-> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   read_pulse_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside answer cycle");
   eeprom_blocks_a: assert property (i_eeprom_present [*4] |-> !o_attributes_active)
      else $error("attributes active with memory image present");
   otp_blocks_a: assert property (i_otp_configured [*4] |-> !o_attributes_active)
      else $error("attributes active with programmed image");
   fields_hold_a: assert property (quiet |=> $stable(o_attributes))
      else $error("attributes changed without cause");
endmodule
bind descriptor_attribute_registers desc_attr_chk u_chk (.i_sys_clk, .i_sys_rst, .i_addr,
   .i_wr, .i_rd, .i_eeprom_present, .i_otp_configured, .i_image_load, .i_usb_reset,
   .i_lite_reset, .o_rdata, .o_attributes_active, .o_attributes);
`default_nettype wire

/* File: descriptor_attribute_registers.v */
// Descriptor attribute register bank: full-speed lengths and polling interval,
// string lengths, wake flags, three scratch words and an emulation enable.
// Assumes a synchronous register port from logic on i_sys_clk, and image and
// reset-event inputs that come from other clock domains or pins.
// Every output comes from a flip-flop; read data stand for one cycle only.
// Functional notes
// - Full-speed polling interval in bits 23:16, default 01h, top byte reads zero.
// - USB or lite reset reloads polling interval from image, else 01h.
// - Defaults come from EEPROM image if present, else from OTP image.
// - Size and wake flag fields default to 00h without any image.
// - USB or lite reset restores size and flag fields from image, else zero.
// - Attributes drive descriptor processing only when emulating with no EEPROM or OTP.
// - Attribute, flag and scratch registers survive protected resets untouched.
// - String register 0 holds config, serial, product, manufacturer lengths.
// - String register 1 holds interface string length in bits 7:0.
// - Wake flag register holds high flags 15:8 and low flags 7:0.
// - Three read/write scratch words at 06Ch through 077h, reset zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "descriptor_attribute_regs.vh"

module descriptor_attribute_registers (
   input  wire        i_sys_clk,
   input  wire        i_sys_rst,
   input  wire [11:0] i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire        i_eeprom_present,
   input  wire        i_otp_configured,
   input  wire [79:0] i_image,
   input  wire        i_image_load,
   input  wire        i_usb_reset,
   input  wire        i_lite_reset,
   output reg  [31:0] o_rdata,
   output reg         o_attributes_active,
   output reg  [79:0] o_attributes
);

   // Image field order, low to high: cfg, dev, poll, manuf, prod, serial, cfgstr,
   // intf, flags low, flags high. Ten byte fields.
   localparam integer NFIELDS = 10;
   localparam integer POLL_IDX = 2;

   // Register select codes produced by the address decode.
   localparam [3:0] SEL_NONE      = 4'h0;
   localparam [3:0] SEL_FS        = 4'h1;
   localparam [3:0] SEL_STR0      = 4'h2;
   localparam [3:0] SEL_STR1      = 4'h3;
   localparam [3:0] SEL_FLAGS     = 4'h4;
   localparam [3:0] SEL_SCRATCH_0 = 4'h5;
   localparam [3:0] SEL_SCRATCH_1 = 4'h6;
   localparam [3:0] SEL_SCRATCH_2 = 4'h7;
   localparam [3:0] SEL_CONTROL   = 4'h8;

   // Two-stage synchronisers for all inputs from outside the clock domain.
   // The image word crosses as a quasi-static bus: it is held steady around a
   // load, and the load edge comes through the same two stages, so the word
   // has settled in image_b before any logic looks at it.
   reg [4:0]  sync_a;
   reg [4:0]  sync_b;
   reg [79:0] image_a;
   reg [79:0] image_b;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_a  <= 5'h00;
         sync_b  <= 5'h00;
         image_a <= 80'h0;
         image_b <= 80'h0;
      end else begin
         sync_a  <= {i_eeprom_present, i_otp_configured, i_image_load,
                     i_usb_reset, i_lite_reset};
         sync_b  <= sync_a;
         image_a <= i_image;
         image_b <= image_a;
      end
   end

   wire eeprom_present = sync_b[4];
   wire otp_configured = sync_b[3];
   wire image_load     = sync_b[2];
   wire soft_reset     = sync_b[1] | sync_b[0];

   // An image exists only behind an EEPROM or a configured OTP.
   wire image_source   = eeprom_present | otp_configured;

   // Edge detection on the synchronised load and reset events.
   // Both history bits start low, the idle level of the pins, so no false edge follows reset.
   reg load_q;
   reg soft_q;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         load_q <= 1'h0;
         soft_q <= 1'h0;
      end else begin
         load_q <= image_load;
         soft_q <= soft_reset;
      end
   end
   wire load_pulse = image_load & ~load_q;
   wire soft_pulse = soft_reset & ~soft_q;

   // Last loaded image is kept so a USB or lite reset can restore it.
   reg        image_valid;
   reg [79:0] image_store;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         image_valid <= 1'h0;
         image_store <= 80'h0;
      end else if (load_pulse) begin
         // Only an EEPROM or a configured OTP yields an image.
         image_valid <= image_source;
         image_store <= image_b;
      end
   end

   // Fallback value of one field when no image is available.
   // Only the polling interval falls back to a non-zero value.
   function [7:0] fallback;
      input integer idx;
      begin
         if (idx == POLL_IDX)
            fallback = `RESET_FS_POLL_INTERVAL;
         else
            fallback = `RESET_LENGTH_FIELD;
      end
   endfunction

   // Register index decode, shared by write and read paths.
   // Unlisted offsets fall to SEL_NONE, which writes nothing and reads zero.
   function [3:0] decode;
      input [11:0] a;
      begin
         case (a)
            `ADDR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES: decode = SEL_FS;
            `ADDR_STRING_LENGTH_ATTRIBUTES_0:       decode = SEL_STR0;
            `ADDR_STRING_LENGTH_ATTRIBUTES_1:       decode = SEL_STR1;
            `ADDR_WAKE_FLAG_ATTRIBUTES:             decode = SEL_FLAGS;
            `ADDR_SOFTWARE_SCRATCH_0:               decode = SEL_SCRATCH_0;
            `ADDR_SOFTWARE_SCRATCH_1:               decode = SEL_SCRATCH_1;
            `ADDR_SOFTWARE_SCRATCH_2:               decode = SEL_SCRATCH_2;
            `ADDR_EMULATION_CONTROL:                decode = SEL_CONTROL;
            default:                                decode = SEL_NONE;
         endcase
      end
   endfunction

   wire [3:0] wsel = decode(i_addr);
   wire [3:0] rsel = decode(i_addr);

   // Which byte fields a write to the addressed register covers, and the byte
   // of write data each field takes. Reserved bytes are in no field.
   reg [NFIELDS-1:0] wr_field;
   reg [79:0]        wr_bytes;
   always @* begin
      wr_field = {NFIELDS{1'b0}};
      wr_bytes = 80'h0;
      if (i_wr) begin
         // A load, USB or lite reset in the same cycle outranks this write.
         case (wsel)
            SEL_FS: begin
               wr_field[2:0] = 3'h7;
               wr_bytes[23:0] = i_wdata[23:0];
            end
            SEL_STR0: begin
               wr_field[6:3] = 4'hF;
               wr_bytes[55:24] = i_wdata[31:0];
            end
            SEL_STR1: begin
               wr_field[7] = 1'b1;
               wr_bytes[63:56] = i_wdata[7:0];
            end
            SEL_FLAGS: begin
               wr_field[9:8] = 2'h3;
               wr_bytes[79:64] = i_wdata[15:0];
            end
            default: begin
               wr_field = {NFIELDS{1'b0}};
            end
         endcase
      end
   end

   // Attribute fields. Only the system reset and the USB or lite reset touch
   // them; any other protected reset of the chip does not reach this bank.
   // Each byte lives in its own register so that every bit has one driver.
   wire [79:0] attr;
   genvar g;
   generate
      for (g = 0; g < NFIELDS; g = g + 1) begin : field
         reg [7:0] value;
         always @(posedge i_sys_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               value <= fallback(g);
            end else if (load_pulse | soft_pulse) begin
               // A fresh load takes the incoming image; a USB or lite reset
               // takes the stored one.
               if (load_pulse & image_source)
                  value <= image_b[g*8 +: 8];
               else if (soft_pulse & image_valid)
                  value <= image_store[g*8 +: 8];
               else
                  value <= fallback(g);
            end else if (wr_field[g]) begin
               // Writes are accepted regardless of image state; software is
               // expected not to write while an image exists.
               value <= wr_bytes[g*8 +: 8];
            end
         end
         assign attr[g*8 +: 8] = value;
      end
   endgenerate

   // Named views of the attribute bytes, in image order.
   wire [7:0] full_speed_config_desc_length = attr[7:0];
   wire [7:0] full_speed_device_desc_length = attr[15:8];
   wire [7:0] full_speed_poll_interval      = attr[23:16];
   wire [7:0] manufacturer_string_length    = attr[31:24];
   wire [7:0] product_name_string_length    = attr[39:32];
   wire [7:0] serial_number_string_length   = attr[47:40];
   wire [7:0] configuration_string_length   = attr[55:48];
   wire [7:0] interface_string_length       = attr[63:56];
   wire [7:0] gpio_wake_flags_low           = attr[71:64];
   wire [7:0] gpio_wake_flags_high          = attr[79:72];

   // Scratch words; they ignore USB and lite reset, so host software can keep
   // notes across a bus reset. Only the system reset clears them.
   reg [31:0] scratch [0:2];
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scratch[0] <= `RESET_SCRATCH;
         scratch[1] <= `RESET_SCRATCH;
         scratch[2] <= `RESET_SCRATCH;
      end else if (i_wr) begin
         if (wsel == SEL_SCRATCH_0)
            scratch[0] <= i_wdata;
         if (wsel == SEL_SCRATCH_1)
            scratch[1] <= i_wdata;
         if (wsel == SEL_SCRATCH_2)
            scratch[2] <= i_wdata;
      end
   end

   // Emulation enable. It does not block attribute writes while an image
   // exists; keeping away from them then stays the duty of software.
   reg emulation_enable;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         emulation_enable <= `RESET_EMULATION_ENABLE;
      else if (i_wr && (wsel == SEL_CONTROL))
         emulation_enable <= i_wdata[0];
   end

   // Read data, registered, valid the cycle after the read strobe.
   // Unmapped addresses and reserved bits read as zero.
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = 32'h0000_0000;
      case (rsel)
         SEL_FS: next_rdata = {8'h00, full_speed_poll_interval,
                               full_speed_device_desc_length,
                               full_speed_config_desc_length};
         SEL_STR0: next_rdata = {configuration_string_length,
                                 serial_number_string_length,
                                 product_name_string_length,
                                 manufacturer_string_length};
         SEL_STR1: next_rdata = {24'h000000, interface_string_length};
         SEL_FLAGS: next_rdata = {16'h0000, gpio_wake_flags_high, gpio_wake_flags_low};
         SEL_SCRATCH_0: next_rdata = scratch[0];
         SEL_SCRATCH_1: next_rdata = scratch[1];
         SEL_SCRATCH_2: next_rdata = scratch[2];
         // Control word: image source status beside the enable bit.
         SEL_CONTROL: next_rdata = {28'h0000000, eeprom_present, otp_configured,
                                    image_valid, emulation_enable};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Data fall back to zero outside the answer cycle, so stale data never linger.
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         o_rdata <= 32'h0000_0000;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= 32'h0000_0000;
   end

   // Attribute outputs to descriptor processing; registered to keep the
   // outputs glitch free. They only count while emulation applies.
   wire next_attributes_active = emulation_enable & ~image_source;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_attributes_active <= 1'h0;
         // Same bytes the fields hold in reset, so nothing jumps at release.
         o_attributes        <= {56'h0, `RESET_FS_POLL_INTERVAL, 16'h0000};
      end else begin
         o_attributes_active <= next_attributes_active;
         o_attributes        <= attr;
      end
   end

endmodule

`default_nettype wire

/* File: descriptor_attribute_registers_tb_top.sv */
// Self-checking bench for the descriptor attribute bank.
// Assumes the bank and its checker are compiled first; the bench drives every input.
`timescale 1ns/10ps
`default_nettype none
module descriptor_attribute_registers_tb_top;
   localparam logic [79:0] FALLBACK = 80'h0000_0000_0000_0001_0000;
   logic        i_sys_clk, i_sys_rst, i_wr, i_rd, i_eeprom_present, i_otp_configured;
   logic        i_image_load, i_usb_reset, i_lite_reset;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, seed, w;
   logic [79:0] i_image, f, img;
   logic [31:0] sc [3];
   wire  [31:0] o_rdata;
   wire         o_attributes_active;
   wire  [79:0] o_attributes;
   int          fails, n_tests;
   descriptor_attribute_registers u_dut (.i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
      .i_rd, .i_eeprom_present, .i_otp_configured, .i_image, .i_image_load, .i_usb_reset,
      .i_lite_reset, .o_rdata, .o_attributes_active, .o_attributes);
   // Free-running 50 MHz clock.
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Register view of the expected field bytes; reserved bits are zero.
   function automatic logic [31:0] view(input logic [11:0] a);
      case (a)
         12'h05C: view = {8'h00, f[23:0]};
         12'h060: view = f[55:24];
         12'h064: view = {24'h0, f[63:56]};
         12'h068: view = {16'h0, f[79:64]};
         default: view = sc[(a - 12'h06C) >> 2];
      endcase
   endfunction
   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // The strobe is dropped for a cycle so that no signal is assigned twice in one step.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      @(negedge i_sys_clk);
      check(80'(o_rdata), 80'(exp));
      @(posedge i_sys_clk);
   endtask
   task automatic chk_all();
      for (int j = 0; j < 7; j++)
         rd(12'h05C + 12'(4 * j), view(12'h05C + 12'(4 * j)));
      check(o_attributes, f);
   endtask
   // Levels held long enough to pass the two-stage synchronisers.
   task automatic evt(input logic ld, input logic usb, input logic lite);
      i_image_load <= ld;
      i_usb_reset  <= usb;
      i_lite_reset <= lite;
      repeat (4) @(posedge i_sys_clk);
      {i_image_load, i_usb_reset, i_lite_reset} <= 3'h0;
      repeat (6) @(posedge i_sys_clk);
   endtask
   task automatic load(input logic ee, input logic otp);
      img = (ee || otp) ? {16'(rnd()), rnd(), rnd()} : FALLBACK;
      i_image          <= img;
      i_eeprom_present <= ee;
      i_otp_configured <= otp;
      repeat (4) @(posedge i_sys_clk);
      evt(1'b1, 1'b0, 1'b0);
      f = img;
      chk_all();
   endtask
   // Random fields with reserved bits set; size fields only take legal lengths.
   task automatic scramble();
      w = rnd();
      f[23:0] = {w[23:16], w[8] ? 8'h12 : 8'h00, w[0] ? 8'h12 : 8'h00};
      wr(12'h05C, {8'hFF, f[23:0]});
      w = rnd();
      f[55:24] = w;
      wr(12'h060, w);
      w = rnd();
      f[63:56] = w[7:0];
      wr(12'h064, w | 32'hFFFF_FF00);
      w = rnd();
      f[79:64] = w[15:0];
      wr(12'h068, w | 32'hFFFF_0000);
      for (int j = 0; j < 3; j++) sc[j] = rnd();
      for (int j = 0; j < 3; j++) wr(12'h06C + 12'(4 * j), sc[j]);
      wr(12'h078, rnd());
      rd(12'h078, 32'h0);
      chk_all();
   endtask
   task automatic rst();
      i_sys_rst <= 1'b1;
      repeat (12) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      f = FALLBACK;
      img = FALLBACK;
      sc = '{default: 32'h0};
   endtask
   // A hang is cut short here and counted as a mismatch.
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      fails++;
      $display("mismatch at %0t: run did not finish", $time);
      end_sim();
   end
   initial begin
      {i_sys_rst, i_wr, i_rd, i_eeprom_present, i_otp_configured} = 5'h10;
      {i_image_load, i_usb_reset, i_lite_reset, i_addr, i_wdata, i_image} = '0;
      {seed, fails, n_tests} = {32'h0000_0010, 32'h0000_0000, 32'h0000_0000};
      rst();
      chk_all();
      check(80'(o_attributes_active), 80'h0);
      repeat (4) scramble();
      evt(1'b0, 1'b1, 1'b0);
      f = img;
      chk_all();
      wr(12'h07C, 32'h1);
      repeat (4) @(posedge i_sys_clk);
      check(80'(o_attributes_active), 80'h1);
      rd(12'h07C, 32'h0000_0001);
      load(1'b1, 1'b0);
      check(80'(o_attributes_active), 80'h0);
      rd(12'h07C, 32'h0000_000B);
      load(1'b0, 1'b1);
      check(80'(o_attributes_active), 80'h0);
      rd(12'h07C, 32'h0000_0007);
      // Attribute writes wait until the OTP is seen gone.
      i_otp_configured <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      scramble();
      evt(1'b0, 1'b0, 1'b1);
      f = img;
      chk_all();
      load(1'b0, 1'b0);
      check(80'(o_attributes_active), 80'h1);
      rd(12'h07C, 32'h0000_0001);
      scramble();
      evt(1'b0, 1'b1, 1'b0);
      f = img;
      chk_all();
      rst();
      chk_all();
      end_sim();
   end
endmodule
`default_nettype wire

/* File: descriptor_attribute_regs.vh */
// Register offsets, field positions and fallback values of the descriptor attribute bank.
// Included by the bank module; holds definitions only.
`ifndef DESCRIPTOR_ATTRIBUTE_REGS_VH
`define DESCRIPTOR_ATTRIBUTE_REGS_VH

`define ADDR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES 12'h05C
`define ADDR_STRING_LENGTH_ATTRIBUTES_0       12'h060
`define ADDR_STRING_LENGTH_ATTRIBUTES_1       12'h064
`define ADDR_WAKE_FLAG_ATTRIBUTES             12'h068
`define ADDR_SOFTWARE_SCRATCH_0               12'h06C
`define ADDR_SOFTWARE_SCRATCH_1               12'h070
`define ADDR_SOFTWARE_SCRATCH_2               12'h074
`define ADDR_EMULATION_CONTROL                12'h07C

`define FS_POLL_MSB      23
`define FS_POLL_LSB      16
`define FS_DEV_MSB       15
`define FS_DEV_LSB       8
`define FS_CFG_MSB       7
`define FS_CFG_LSB       0

`define RESET_FS_POLL_INTERVAL 8'h01
`define RESET_LENGTH_FIELD     8'h00
`define RESET_SCRATCH          32'h0000_0000
`define RESET_EMULATION_ENABLE 1'h0

`endif
